// ---- logic/fmw_pkg.sv ----
// Purpose: Shared constants and types for the frame memory window addresser.
// Assumes: Avalon-MM slave with 32-bit data and byte addresses, one 100 MHz clock.
// Notes: Offsets are byte addresses, one aligned word per register.
//
// What this block does
// [RULE1] see: pixel words stream into window, pointer self-advances
// [RULE2] see: 8-bit column start and end bounds
// [RULE3] see: 8-bit line start and end bounds
// [RULE4] see: host keeps start<=end, ends within AF/BD
// [RULE5] see: host sets pointer inside window first
// [RULE6] see: pointer is line high byte, column low
// [RULE7] see: scan axis 0 moves along line first
// [RULE8] see: step direction 1 increments the pointer
// [RULE9] see: device wraps at window edges by itself
// [RULE10] see: fast axis reloads start (end when decrementing), slow steps, rewinds
// [RULE11] see: busy and deaf while reset is active
// [RULE12] see: host holds reset at least 1 ms
// [RULE13] see: host waits 1 ms after power-on
// [RULE14] see: memory contents untouched by reset
// [RULE15] see: host avoids reset during deep standby
// [RULE16] see: host resynchronises split transfers after reset
package fmw_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [4:0] FMW_OFS_CTRL = 5'h00;
    localparam logic [4:0] FMW_OFS_HWIN = 5'h04;
    localparam logic [4:0] FMW_OFS_VWIN = 5'h08;
    localparam logic [4:0] FMW_OFS_PTR = 5'h0c;
    localparam logic [4:0] FMW_OFS_DATA = 5'h10;
    localparam logic [4:0] FMW_OFS_STAT = 5'h14;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int FMW_CTRL_AXIS_BIT = 0;
    localparam int FMW_CTRL_INC_BIT = 1;
    localparam int FMW_STAT_PEND_BIT = 0;
    localparam int FMW_STAT_FULL_BIT = 1;
    localparam int FMW_PIX_W = 18;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic FMW_RST_AXIS = 1'b0;
    localparam logic FMW_RST_INC = 1'b1;
    localparam logic [7:0] FMW_RST_COL_START = 8'h00;
    localparam logic [7:0] FMW_RST_COL_END = 8'haf;
    localparam logic [7:0] FMW_RST_LINE_START = 8'h00;
    localparam logic [7:0] FMW_RST_LINE_END = 8'hbd;
    localparam logic [15:0] FMW_RST_PTR = 16'h0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [FMW_PIX_W-1:0] pixel;
    } fmw_word_s;

endpackage

// ---- logic/fmw_skid_buf.sv ----
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Outputs come straight from flip-flops; no word is lost on a stall.
`timescale 1ns/10ps
module fmw_skid_buf
    import fmw_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire fmw_word_s in_word_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output fmw_word_s out_word_o,
    input wire logic out_ready_i
);

    logic [1:0] cnt_r;
    fmw_word_s skid_r;
    logic push_w;
    logic pop_w;

    assign push_w = in_valid_i & in_ready_o;
    assign pop_w = out_valid_o & out_ready_i;

    // ****************************************************************
    // Occupancy and flags
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= 2'd0;
            out_valid_o <= 1'b0;
            in_ready_o <= 1'b1;
        end else begin
            case ({push_w, pop_w})
                2'b10: begin
                    cnt_r <= cnt_r + 2'd1;
                    out_valid_o <= 1'b1;
                    in_ready_o <= (cnt_r == 2'd0);
                end
                2'b01: begin
                    cnt_r <= cnt_r - 2'd1;
                    out_valid_o <= (cnt_r == 2'd2);
                    in_ready_o <= 1'b1;
                end
                default: begin
                    cnt_r <= cnt_r;
                end
            endcase
        end
    end

    // ****************************************************************
    // Data path
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            out_word_o <= '0;
            skid_r <= '0;
        end else begin
            if (cnt_r == 2'd2 && pop_w) begin
                out_word_o <= skid_r;
            end else if (push_w && (cnt_r == 2'd0 || pop_w)) begin
                out_word_o <= in_word_i;
            end else if (push_w) begin
                skid_r <= in_word_i;
            end
        end
    end

endmodule

// ---- logic/fmw_window_addr.sv ----
// Purpose: Window address generator for host pixel writes into frame memory.
// Assumes: Avalon-MM slave with waitrequest; frame memory port on the same clock.
// Notes: Frame memory contents are never cleared here; only pushed words write it.
`timescale 1ns/10ps
module fmw_window_addr
    import fmw_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Frame memory write port
    output logic fm_wr_o,
    output logic [15:0] fm_addr_o,
    output logic [FMW_PIX_W-1:0] fm_data_o,
    input wire logic fm_ready_i,
    // Status
    output logic busy_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic scan_axis_sel_r;
    logic step_inc_r;
    logic [7:0] win_col_start_r;
    logic [7:0] win_col_end_r;
    logic [7:0] win_line_start_r;
    logic [7:0] win_line_end_r;
    logic [15:0] ram_ptr_r;
    logic [15:0] ram_ptr_nxt;
    logic [31:0] rdata_nxt;
    logic [31:0] hwin_mrg;
    logic [31:0] vwin_mrg;
    logic [31:0] ptr_mrg;
    logic req_w;
    logic acc_w;
    logic wr_acc_w;
    logic can_go_w;
    logic push_w;
    logic buf_in_ready;
    logic buf_out_valid;
    fmw_word_s buf_in_word;
    fmw_word_s buf_out_word;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        be_merge = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic at_edge(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi, input logic up);
        at_edge = up ? (v == hi) : (v == lo);
    endfunction

    function automatic logic [7:0] adv(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi, input logic up);
        if (up) begin
            adv = (v == hi) ? lo : v + 8'h01;
        end else begin
            adv = (v == lo) ? hi : v - 8'h01;
        end
    endfunction

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    assign req_w = avs_read_i | avs_write_i;
    assign acc_w = req_w & ~avs_waitrequest_o;
    assign wr_acc_w = acc_w & avs_write_i;
    assign can_go_w = ~(avs_write_i && avs_address_i == FMW_OFS_DATA) | buf_in_ready;
    assign push_w = wr_acc_w && (avs_address_i == FMW_OFS_DATA); // see [RULE1]
    assign hwin_mrg = be_merge({16'h0000, win_col_end_r, win_col_start_r},
                               avs_writedata_i, avs_byteenable_i);
    assign vwin_mrg = be_merge({16'h0000, win_line_end_r, win_line_start_r},
                               avs_writedata_i, avs_byteenable_i);
    assign ptr_mrg = be_merge({16'h0000, ram_ptr_r}, avs_writedata_i, avs_byteenable_i);

    // Requests are answered one cycle after they are seen, a data write
    // only while the buffer has room, so a stalled memory stalls the host.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1; // see [RULE11]
            avs_readdata_o <= 32'h0000_0000;
        end else if (req_w && avs_waitrequest_o && can_go_w) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= rdata_nxt;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Busy flag follows reset.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b1; // see [RULE11]
        end else begin
            busy_o <= 1'b0;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (avs_address_i == FMW_OFS_CTRL) begin
            rdata_nxt[FMW_CTRL_AXIS_BIT] = scan_axis_sel_r;
            rdata_nxt[FMW_CTRL_INC_BIT] = step_inc_r;
        end else if (avs_address_i == FMW_OFS_HWIN) begin
            rdata_nxt[15:0] = {win_col_end_r, win_col_start_r};
        end else if (avs_address_i == FMW_OFS_VWIN) begin
            rdata_nxt[15:0] = {win_line_end_r, win_line_start_r};
        end else if (avs_address_i == FMW_OFS_PTR) begin
            rdata_nxt[15:0] = ram_ptr_r;
        end else if (avs_address_i == FMW_OFS_STAT) begin
            rdata_nxt[FMW_STAT_PEND_BIT] = buf_out_valid;
            rdata_nxt[FMW_STAT_FULL_BIT] = ~buf_in_ready;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            scan_axis_sel_r <= FMW_RST_AXIS;
            step_inc_r <= FMW_RST_INC;
        end else if (wr_acc_w && avs_address_i == FMW_OFS_CTRL && avs_byteenable_i[0]) begin
            scan_axis_sel_r <= avs_writedata_i[FMW_CTRL_AXIS_BIT]; // see [RULE7]
            step_inc_r <= avs_writedata_i[FMW_CTRL_INC_BIT]; // see [RULE8]
        end
    end

    // Horizontal window bounds.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            win_col_start_r <= FMW_RST_COL_START;
            win_col_end_r <= FMW_RST_COL_END;
        end else if (wr_acc_w && avs_address_i == FMW_OFS_HWIN) begin
            {win_col_end_r, win_col_start_r} <= hwin_mrg[15:0]; // see [RULE2]
        end
    end

    // Vertical window bounds.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            win_line_start_r <= FMW_RST_LINE_START;
            win_line_end_r <= FMW_RST_LINE_END;
        end else if (wr_acc_w && avs_address_i == FMW_OFS_VWIN) begin
            {win_line_end_r, win_line_start_r} <= vwin_mrg[15:0]; // see [RULE3]
        end
    end

    // ****************************************************************
    // Pointer advance
    // ****************************************************************
    // The fast axis wraps to its start bound (end bound when decrementing) and steps the slow axis; the
    // last location of the window wraps back to the first one.
    always_comb begin
        ram_ptr_nxt = ram_ptr_r;
        if (!scan_axis_sel_r) begin
            ram_ptr_nxt[7:0] = adv(ram_ptr_r[7:0], win_col_start_r, win_col_end_r,
                                   step_inc_r); // see [RULE7]
            if (at_edge(ram_ptr_r[7:0], win_col_start_r, win_col_end_r, step_inc_r)) begin
                ram_ptr_nxt[15:8] = adv(ram_ptr_r[15:8], win_line_start_r,
                                        win_line_end_r, step_inc_r); // see [RULE10]
            end
        end else begin
            ram_ptr_nxt[15:8] = adv(ram_ptr_r[15:8], win_line_start_r, win_line_end_r,
                                    step_inc_r); // see [RULE8]
            if (at_edge(ram_ptr_r[15:8], win_line_start_r, win_line_end_r,
                        step_inc_r)) begin
                ram_ptr_nxt[7:0] = adv(ram_ptr_r[7:0], win_col_start_r, win_col_end_r,
                                       step_inc_r); // see [RULE9]
            end
        end
    end

    // Pointer: line in the high byte, column in the low byte.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ram_ptr_r <= FMW_RST_PTR;
        end else if (wr_acc_w && avs_address_i == FMW_OFS_PTR) begin
            ram_ptr_r <= ptr_mrg[15:0]; // see [RULE6]
        end else if (push_w) begin
            ram_ptr_r <= ram_ptr_nxt; // see [RULE1]
        end
    end

    // ****************************************************************
    // Pixel buffer toward frame memory
    // ****************************************************************
    assign buf_in_word = '{addr: ram_ptr_r, pixel: avs_writedata_i[FMW_PIX_W-1:0]};

    fmw_skid_buf fmw_skid_buf_inst (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(push_w),
        .in_word_i(buf_in_word),
        .in_ready_o(buf_in_ready),
        .out_valid_o(buf_out_valid),
        .out_word_o(buf_out_word),
        .out_ready_i(fm_ready_i)
    );

    assign fm_wr_o = buf_out_valid;
    assign fm_addr_o = buf_out_word.addr;
    assign fm_data_o = buf_out_word.pixel;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_data_push;
        push_w && !buf_out_valid;
    endsequence

    sequence s_word_out(logic [15:0] a);
        fm_wr_o && fm_addr_o == a;
    endsequence

    property p_push_reaches_memory;
        logic [15:0] a;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (s_data_push, a = ram_ptr_r) |=> s_word_out(a);
    endproperty
    a_push_reaches_memory: assert property (p_push_reaches_memory) // see [RULE1]
        else $error("pushed pixel did not reach memory port with its address");

    property p_hwin_write;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_acc_w && avs_address_i == FMW_OFS_HWIN && avs_byteenable_i[1:0] == 2'b11
        |=> win_col_start_r == $past(avs_writedata_i[7:0])
            && win_col_end_r == $past(avs_writedata_i[15:8]);
    endproperty
    a_hwin_write: assert property (p_hwin_write) // see [RULE2]
        else $error("column bounds not loaded from bus write");

    property p_vwin_write;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_acc_w && avs_address_i == FMW_OFS_VWIN && avs_byteenable_i[1:0] == 2'b11
        |=> win_line_start_r == $past(avs_writedata_i[7:0])
            && win_line_end_r == $past(avs_writedata_i[15:8]);
    endproperty
    a_vwin_write: assert property (p_vwin_write) // see [RULE3]
        else $error("line bounds not loaded from bus write");

    property p_horiz_inc;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        push_w && !scan_axis_sel_r && step_inc_r && ram_ptr_r[7:0] != win_col_end_r
        |=> ram_ptr_r[7:0] == $past(ram_ptr_r[7:0]) + 8'h01
            && $stable(ram_ptr_r[15:8]);
    endproperty
    a_horiz_inc: assert property (p_horiz_inc) // see [RULE7]
        else $error("horizontal increment did not step the column by one");

    property p_horiz_dec;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        push_w && !scan_axis_sel_r && !step_inc_r && ram_ptr_r[7:0] != win_col_start_r
        |=> ram_ptr_r[7:0] == $past(ram_ptr_r[7:0]) - 8'h01;
    endproperty
    a_horiz_dec: assert property (p_horiz_dec) // see [RULE8]
        else $error("decrement did not lower the column by one");

    property p_vert_inc;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        push_w && scan_axis_sel_r && step_inc_r && ram_ptr_r[15:8] != win_line_end_r
        |=> ram_ptr_r[15:8] == $past(ram_ptr_r[15:8]) + 8'h01
            && $stable(ram_ptr_r[7:0]);
    endproperty
    a_vert_inc: assert property (p_vert_inc) // see [RULE6]
        else $error("vertical scan did not step the line byte");

    property p_line_wrap;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        push_w && !scan_axis_sel_r && step_inc_r && ram_ptr_r[7:0] == win_col_end_r
            && ram_ptr_r[15:8] != win_line_end_r
        |=> ram_ptr_r[7:0] == win_col_start_r
            && ram_ptr_r[15:8] == $past(ram_ptr_r[15:8]) + 8'h01;
    endproperty
    a_line_wrap: assert property (p_line_wrap) // see [RULE9]
        else $error("column end did not wrap to start and next line");

    property p_window_rewind;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        push_w && !scan_axis_sel_r && step_inc_r && ram_ptr_r[7:0] == win_col_end_r
            && ram_ptr_r[15:8] == win_line_end_r
        |=> ram_ptr_r == {win_line_start_r, win_col_start_r};
    endproperty
    a_window_rewind: assert property (p_window_rewind) // see [RULE10]
        else $error("last window location did not return to the first");

    property p_reset_busy;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> busy_o && avs_waitrequest_o && !fm_wr_o ##1 !busy_o;
    endproperty
    a_reset_busy: assert property (p_reset_busy) // see [RULE11]
        else $error("block not busy and deaf across reset release");

    property p_mem_only_by_push;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(fm_wr_o) |-> $past(push_w);
    endproperty
    a_mem_only_by_push: assert property (p_mem_only_by_push) // see [RULE14]
        else $error("memory write started without a pixel push");

endmodule

// ---- testbench/fmw_mem_model.sv ----
// Purpose: Frame memory model that takes words from the window addresser.
// Assumes: One clock shared with the design; the model has no reset input.
// Notes: mode_i 0 always ready, 1 random stalls, 2 stalls until changed.
`timescale 1ns/10ps
module fmw_mem_model
    import fmw_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Write port
    input wire logic fm_wr_i,
    input wire logic [15:0] fm_addr_i,
    input wire logic [FMW_PIX_W-1:0] fm_data_i,
    output logic fm_ready_o,
    // Control
    input wire logic [1:0] mode_i
);
    logic [FMW_PIX_W-1:0] mem [logic [15:0]];

    initial fm_ready_o = 1'b0;

    // ****************************************************************
    // Back-pressure and storage
    // ****************************************************************
    always @(posedge core_clk_i) begin
        fm_ready_o <= (mode_i == 2'd0) ? 1'b1 : (mode_i == 2'd1) ? 1'($urandom % 2) : 1'b0;
    end

    // Contents survive any reset; only accepted words change them.
    always @(posedge core_clk_i) begin
        if (fm_wr_i === 1'b1 && fm_ready_o === 1'b1) begin
            mem[fm_addr_i] = fm_data_i;
        end
    end
endmodule

// ---- testbench/test_frame_memory_window_addressing.sv ----
// Purpose: Self-checking bench for the window address generator.
// Assumes: 100 MHz clock, Avalon-MM master tasks, queue-based scoreboard.
// Notes: Expected pointer walk is computed here from the window settings.
`timescale 1ns/10ps
module test_frame_memory_window_addressing;
    import fmw_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, fm_wr_o, fm_ready, busy_o;
    logic [15:0] fm_addr_o;
    logic [FMW_PIX_W-1:0] fm_data_o;
    logic [1:0] mode = 2'd0;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    fmw_word_s exp_q[$];
    logic axis, inc;
    logic [7:0] hs, he, vs, ve;
    logic [15:0] ptr;
    logic [31:0] rd;

    fmw_window_addr fmw_window_addr_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .fm_wr_o(fm_wr_o), .fm_addr_o(fm_addr_o), .fm_data_o(fm_data_o),
        .fm_ready_i(fm_ready), .busy_o(busy_o));
    fmw_mem_model fmw_mem_model_inst (.core_clk_i(core_clk_i), .fm_wr_i(fm_wr_o),
        .fm_addr_i(fm_addr_o), .fm_data_i(fm_data_o), .fm_ready_o(fm_ready), .mode_i(mode));

    initial forever #5 core_clk_i = ~core_clk_i;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be);
        int n;
        n = 0;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 500) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n >= 500) check("waitrequest", 32'h1, 32'h0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'hf);
        check(nm, rd, exp);
    endtask

    // Pushes one pixel and notes the word that must reach memory.
    task automatic push_pix();
        logic [FMW_PIX_W-1:0] pix;
        logic [7:0] f, s, fs, fe, ss, se;
        pix = FMW_PIX_W'($urandom);
        exp_q.push_back('{addr: ptr, pixel: pix});
        xfer(1'b1, FMW_OFS_DATA, 32'(pix), 4'hf);
        {fs, fe, ss, se} = axis ? {vs, ve, hs, he} : {hs, he, vs, ve};
        {s, f} = axis ? {ptr[7:0], ptr[15:8]} : ptr;
        if (inc) begin
            s = (f != fe) ? s : (s == se) ? ss : s + 8'h1;
            f = (f == fe) ? fs : f + 8'h1;
        end else begin
            s = (f != fs) ? s : (s == ss) ? se : s - 8'h1;
            f = (f == fs) ? fe : f - 8'h1;
        end
        ptr = axis ? {f, s} : {s, f};
    endtask

    task automatic drain();
        int n;
        for (n = 0; n < 400 && exp_q.size() != 0; n++) @(posedge core_clk_i);
        repeat (2) @(posedge core_clk_i);
    endtask

    // ****************************************************************
    // Scoreboard and timeout
    // ****************************************************************
    always @(posedge core_clk_i) begin
        fmw_word_s w;
        if (sys_rst_i === 1'b0 && fm_wr_o === 1'b1 && fm_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("fm_unexpected", {16'h0, fm_addr_o}, 32'hffffffff);
            end else begin
                w = exp_q.pop_front();
                check("fm_addr", {16'h0, fm_addr_o}, {16'h0, w.addr});
                check("fm_data", 32'(fm_data_o), 32'(w.pixel));
            end
        end
    end

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h8da5d0cc));
        repeat (8) @(posedge core_clk_i);
        check("busy_rst", 32'(busy_o), 32'h1);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check("busy_run", 32'(busy_o), 32'h0);
        rd_chk("ctrl_rst", FMW_OFS_CTRL, 32'h2);
        rd_chk("hwin_rst", FMW_OFS_HWIN, 32'h0000af00);
        rd_chk("vwin_rst", FMW_OFS_VWIN, 32'h0000bd00);
        rd_chk("ptr_rst", FMW_OFS_PTR, 32'h0);
        rd_chk("stat_rst", FMW_OFS_STAT, 32'h0);
        xfer(1'b1, 5'h18, 32'hffffffff, 4'hf);
        rd_chk("unmapped", 5'h18, 32'h0);
        rd_chk("data_rd", FMW_OFS_DATA, 32'h0);
        xfer(1'b1, FMW_OFS_HWIN, 32'h00005533, 4'h1);
        rd_chk("hwin_be", FMW_OFS_HWIN, 32'h0000af33);
        for (int m = 0; m < 4; m++) begin
            {inc, axis} = 2'(m);
            mode <= 2'(m % 2);
            hs = 8'($urandom_range(0, 168));
            he = hs + 8'($urandom_range(1, 4));
            vs = 8'($urandom_range(0, 184));
            ve = vs + 8'($urandom_range(1, 3));
            ptr = {vs + 8'($urandom_range(0, 1)), hs + 8'($urandom_range(0, 1))};
            xfer(1'b1, FMW_OFS_CTRL, {30'h0, inc, axis}, 4'h1);
            xfer(1'b1, FMW_OFS_HWIN, {16'h0, he, hs}, 4'hf);
            xfer(1'b1, FMW_OFS_VWIN, {16'h0, ve, vs}, 4'hf);
            xfer(1'b1, FMW_OFS_PTR, {16'h0, ptr}, 4'hf);
            rd_chk("ctrl", FMW_OFS_CTRL, {30'h0, inc, axis});
            rd_chk("vwin", FMW_OFS_VWIN, {16'h0, ve, vs});
            for (int k = 0; k < 22; k++) push_pix();
            drain();
            rd_chk("ptr_wrap", FMW_OFS_PTR, {16'h0, ptr});
            check("queue_empty", 32'(exp_q.size()), 32'h0);
        end
        mode <= 2'd2;
        push_pix();
        push_pix();
        rd_chk("stat_full", FMW_OFS_STAT, 32'h3);
        mode <= 2'd1;
        drain();
        rd_chk("stat_empty", FMW_OFS_STAT, 32'h0);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        avs_write_i <= 1'b1;
        avs_address_i <= FMW_OFS_HWIN;
        avs_writedata_i <= 32'h00001234;
        avs_byteenable_i <= 4'hf;
        @(posedge core_clk_i);
        repeat (3) begin
            @(posedge core_clk_i);
            check("busy_mid", 32'(busy_o), 32'h1);
            check("wait_mid", 32'(avs_waitrequest_o), 32'h1);
            check("fm_wr_mid", 32'(fm_wr_o), 32'h0);
        end
        avs_write_i <= 1'b0;
        @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check("busy_again", 32'(busy_o), 32'h0);
        rd_chk("hwin_after", FMW_OFS_HWIN, 32'h0000af00);
        end_sim();
    end
endmodule
